/* File: replay_dma_ctrl.sv */
// Purpose: Command/status registers for host transfers and replay sequencer
// Assumes: Register port is the card's native indexed register access
// Notes: Memory datapath and DMA engine sit outside; this block steers them
// Operation
// - Command writes may combine card and transfer bits; all set bits act, except halt and card start, which transfer start and card stop override.
// - Transfer start begins the DMA for the previously defined buffer.
// - Card-to-host start before any trigger is held until the trigger.
// - Wait blocks until done or one notify chunk, limited by timeout.
// - Halt aborts a running transfer; its data counts as invalid.
// - Block-ready flag shows once at least one notify chunk is present.
// - Done flag rises at transfer end, only when notify size is zero.
// - Overrun flag shows FIFO overrun or underrun during transfers.
// - Error flag shows any internal fault during a transfer.
// - Mode register is read-write and reads back the selected mode.
// - Single-trigger mode waits one trigger, then replays per repeat count.
// - Repeat count zero runs until stopped; N replays then stops.
// - Single-trigger with count one plays memory exactly once.
// - Retrigger mode plays whole memory once per trigger, quick re-arm.
// - Retrigger count zero runs until stopped; N stops after N replays.
// - Retrigger with count one behaves like single-trigger mode.
// - Between retriggered replays the output holds the stop level.
// - Replay length is clamped to memory per enabled channel.
// - Outputs step at equidistant sample intervals, independent of host.
// - Zero notify gives one event at end; nonzero one per chunk.
`timescale 1ns/1ps
module replay_dma_ctrl #(
  parameter int ADDR_W = 24
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] regAddr,
  input wire logic regWrEn,
  input wire logic [31:0] regWrData,
  input wire logic regRdEn,
  output logic [31:0] regRdData,
  output logic regRdValid,
  input wire logic acqDirection,
  input wire logic [31:0] notifyChunkBytes,
  input wire logic [31:0] xferTotalBytes,
  input wire logic xferBeat,
  input wire logic [31:0] waitTimeoutCycles,
  input wire logic [2:0] enabledChannels,
  input wire logic trigPin,
  input wire logic fifoFault,
  input wire logic internalFault,
  output logic dmaRun,
  output logic [ADDR_W-1:0] memAddr,
  output logic memRdEn,
  output logic stopLevelSel
);
  generate
    if (ADDR_W < 5 || ADDR_W > 31) begin : g_bad_width
      $error("ADDR_W out of range");
    end
  endgenerate
  // Largest replay length the memory holds for the enabled channel count
  function automatic logic [31:0] maxLen(input logic [2:0] ch);
    logic [31:0] full;
    full = 32'(1) << ADDR_W;
    case (ch)
      3'h2: maxLen = full >> 1;
      3'h4: maxLen = full >> 2;
      default: maxLen = full;
    endcase
  endfunction
  // ==========================================================================
  // Register writes
  logic [31:0] mode_r, len_r, loops_r;
  logic cmdWr, cStart, cStop, xStart, xWait, xHalt;
  assign cmdWr = regWrEn && (regAddr == replay_ctrl_pkg::CMD_IDX);
  assign cStart = cmdWr && regWrData[replay_ctrl_pkg::CARD_START_BIT];
  assign cStop = cmdWr && regWrData[replay_ctrl_pkg::CARD_STOP_BIT];
  assign xStart = cmdWr && regWrData[replay_ctrl_pkg::XFER_START_BIT];
  assign xWait = cmdWr && regWrData[replay_ctrl_pkg::XFER_WAIT_BIT];
  assign xHalt = cmdWr && regWrData[replay_ctrl_pkg::XFER_HALT_BIT];
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= replay_ctrl_pkg::MODE_RST;
      len_r <= replay_ctrl_pkg::LEN_RST;
      loops_r <= replay_ctrl_pkg::LOOPS_RST;
    end else if (regWrEn) begin
      // Unknown mode codes are dropped so the readback stays a real mode
      if (regAddr == replay_ctrl_pkg::MODE_IDX &&
          (regWrData == replay_ctrl_pkg::MODE_SINGLE ||
           regWrData == replay_ctrl_pkg::MODE_RETRIG)) begin
        mode_r <= regWrData;
      end
      if (regAddr == replay_ctrl_pkg::LEN_IDX) begin
        len_r <= (regWrData > maxLen(enabledChannels)) ?
                 maxLen(enabledChannels) : regWrData;
      end
      if (regAddr == replay_ctrl_pkg::LOOPS_IDX) begin
        loops_r <= regWrData;
      end
    end
  end
  // ==========================================================================
  // Trigger input
  logic trigLvl, trigPrev_r, trigRise;
  pin_sync #(.WIDTH(1)) u_trig_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn(trigPin),
    .pinOut(trigLvl)
  );
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trigPrev_r <= 1'b0;
    end else begin
      trigPrev_r <= trigLvl;
    end
  end
  assign trigRise = trigLvl && !trigPrev_r;
  // ==========================================================================
  // Transfer control
  logic pend_r, trigSeen_r, lastBeat, chunkHit;
  logic [31:0] byteCnt_r, chunkCnt_r, waitCnt_r;
  logic blkRdy_r, done_r, ovr_r, err_r;
  logic waitBusy_r, waitTmo_r, waitEnd;
  assign lastBeat = dmaRun && xferBeat &&
    ({1'b0, byteCnt_r} + {1'b0, replay_ctrl_pkg::BEAT_BYTES} >=
     {1'b0, xferTotalBytes});
  assign chunkHit = dmaRun && xferBeat && (notifyChunkBytes != '0) &&
    ({1'b0, chunkCnt_r} + {1'b0, replay_ctrl_pkg::BEAT_BYTES} >=
     {1'b0, notifyChunkBytes});
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trigSeen_r <= 1'b0;
    end else if (cStart) begin
      trigSeen_r <= 1'b0;
    end else if (trigRise) begin
      trigSeen_r <= 1'b1;
    end
  end
  // Start takes priority over halt, so halt plus start in one write restarts
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmaRun <= 1'b0;
      pend_r <= 1'b0;
    end else if (xStart) begin
      if (acqDirection && (cStart || (!trigSeen_r && !trigRise))) begin
        dmaRun <= 1'b0;
        pend_r <= 1'b1;
      end else begin
        dmaRun <= 1'b1;
        pend_r <= 1'b0;
      end
    end else if (xHalt) begin
      dmaRun <= 1'b0;
      pend_r <= 1'b0;
    end else if (pend_r && trigRise) begin
      dmaRun <= 1'b1;
      pend_r <= 1'b0;
    end else if (lastBeat) begin
      dmaRun <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byteCnt_r <= '0;
      chunkCnt_r <= '0;
    end else if (xStart || xHalt) begin
      byteCnt_r <= '0;
      chunkCnt_r <= '0;
    end else if (dmaRun && xferBeat) begin
      byteCnt_r <= byteCnt_r + replay_ctrl_pkg::BEAT_BYTES;
      chunkCnt_r <= chunkHit ? '0 :
                    chunkCnt_r + replay_ctrl_pkg::BEAT_BYTES;
    end
  end
  // Flags are sticky; a new start clears them, a halt clears only block-ready and done, an event wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      blkRdy_r <= 1'b0;
      done_r <= 1'b0;
      ovr_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      blkRdy_r <= chunkHit || (blkRdy_r && !(xStart || xHalt));
      done_r <= (lastBeat && notifyChunkBytes == '0) ||
                (done_r && !(xStart || xHalt));
      ovr_r <= (dmaRun && fifoFault) || (ovr_r && !xStart);
      err_r <= (dmaRun && internalFault) || (err_r && !xStart);
    end
  end
  assign waitEnd = blkRdy_r || done_r || err_r || !(dmaRun || pend_r);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waitBusy_r <= 1'b0;
      waitTmo_r <= 1'b0;
      waitCnt_r <= '0;
    end else if (xWait) begin
      waitBusy_r <= 1'b1;
      waitTmo_r <= 1'b0;
      waitCnt_r <= '0;
    end else if (waitBusy_r) begin
      if (waitEnd) begin
        waitBusy_r <= 1'b0;
      end else if (waitTimeoutCycles != '0 &&
                   waitCnt_r + 32'h1 >= waitTimeoutCycles) begin
        waitBusy_r <= 1'b0;
        waitTmo_r <= 1'b1;
      end else begin
        waitCnt_r <= waitCnt_r + 32'h1;
      end
    end
  end
  // ==========================================================================
  // Replay sequencer
  replay_ctrl_pkg::replay_state_t state_r, state_nxt;
  logic [31:0] loopsLeft_r, loopsLeft_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic lastSample, retrig;
  assign retrig = (mode_r == replay_ctrl_pkg::MODE_RETRIG);
  assign lastSample = ({{(32-ADDR_W){1'b0}}, memAddr} + 32'h1 >= len_r);
  always_comb begin
    state_nxt = state_r;
    loopsLeft_nxt = loopsLeft_r;
    addr_nxt = memAddr;
    case (state_r)
      replay_ctrl_pkg::ST_IDLE: begin
        if (cStart) begin
          state_nxt = replay_ctrl_pkg::ST_ARMED;
          loopsLeft_nxt = loops_r;
        end
      end
      replay_ctrl_pkg::ST_ARMED, replay_ctrl_pkg::ST_GAP: begin
        if (trigRise) begin
          state_nxt = replay_ctrl_pkg::ST_PLAY;
          addr_nxt = '0;
        end
      end
      replay_ctrl_pkg::ST_PLAY: begin
        addr_nxt = memAddr + 1'b1;
        if (lastSample) begin
          addr_nxt = '0;
          if (loopsLeft_r == 32'h1) begin
            state_nxt = replay_ctrl_pkg::ST_IDLE;
          end else if (retrig) begin
            state_nxt = replay_ctrl_pkg::ST_GAP;
          end
          if (loopsLeft_r != '0) begin
            loopsLeft_nxt = loopsLeft_r - 32'h1;
          end
        end
      end
      default: state_nxt = replay_ctrl_pkg::ST_IDLE;
    endcase
    if (cStop) begin
      state_nxt = replay_ctrl_pkg::ST_IDLE;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= replay_ctrl_pkg::ST_IDLE;
      loopsLeft_r <= '0;
      memAddr <= '0;
      memRdEn <= 1'b0;
      stopLevelSel <= 1'b1;
    end else begin
      state_r <= state_nxt;
      loopsLeft_r <= loopsLeft_nxt;
      memAddr <= addr_nxt;
      memRdEn <= (state_nxt == replay_ctrl_pkg::ST_PLAY);
      stopLevelSel <= (state_nxt != replay_ctrl_pkg::ST_PLAY);
    end
  end
  // ==========================================================================
  // Register reads
  logic [31:0] statWord;
  always_comb begin
    statWord = '0;
    statWord[replay_ctrl_pkg::BLK_RDY_BIT] = blkRdy_r;
    statWord[replay_ctrl_pkg::DONE_BIT] = done_r;
    statWord[replay_ctrl_pkg::OVR_BIT] = ovr_r;
    statWord[replay_ctrl_pkg::ERR_BIT] = err_r;
    statWord[replay_ctrl_pkg::WAIT_BUSY_BIT] = waitBusy_r;
    statWord[replay_ctrl_pkg::WAIT_TMO_BIT] = waitTmo_r;
    statWord[replay_ctrl_pkg::XFER_RUN_BIT] = dmaRun || pend_r;
    statWord[replay_ctrl_pkg::REPLAY_RUN_BIT] =
      (state_r != replay_ctrl_pkg::ST_IDLE);
  end
  // Reads only sample state; nothing else reacts to them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        case (regAddr)
          replay_ctrl_pkg::STAT_IDX: regRdData <= statWord;
          replay_ctrl_pkg::MODE_IDX: regRdData <= mode_r;
          replay_ctrl_pkg::LEN_IDX: regRdData <= len_r;
          replay_ctrl_pkg::LOOPS_IDX: regRdData <= loops_r;
          default: regRdData <= '0;
        endcase
      end
    end
  end
  // ==========================================================================
  // Checks
  a_start_runs: assert property (@(posedge core_clk) disable iff (!nrst)
    xStart && !acqDirection |=> dmaRun)
    else $error("transfer start did not run");
  a_acq_pending: assert property (@(posedge core_clk) disable iff (!nrst)
    xStart && acqDirection && !trigSeen_r && !trigRise |=> !dmaRun && pend_r)
    else $error("start before trigger not held");
  a_halt_stops: assert property (@(posedge core_clk) disable iff (!nrst)
    xHalt && !xStart |=> !dmaRun && !pend_r && byteCnt_r == '0)
    else $error("halt did not stop transfer");
  a_done_notify: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(done_r) |-> $past(notifyChunkBytes) == '0)
    else $error("done flag with nonzero notify");
  a_block_ready: assert property (@(posedge core_clk) disable iff (!nrst)
    chunkHit |=> blkRdy_r)
    else $error("block ready missed");
  a_wait_ends: assert property (@(posedge core_clk) disable iff (!nrst)
    waitBusy_r && done_r && !xWait |=> !waitBusy_r)
    else $error("wait not released at done");
  a_play_steps: assert property (@(posedge core_clk) disable iff (!nrst)
    state_r == replay_ctrl_pkg::ST_PLAY && !lastSample && !cStop
    |=> memAddr == $past(memAddr) + 1'b1 && memRdEn)
    else $error("replay address did not step");
  a_single_once: assert property (@(posedge core_clk) disable iff (!nrst)
    state_r == replay_ctrl_pkg::ST_PLAY && lastSample && loopsLeft_r == 32'h1
    |=> state_r == replay_ctrl_pkg::ST_IDLE && stopLevelSel)
    else $error("count one replay did not end");
  a_gap_level: assert property (@(posedge core_clk) disable iff (!nrst)
    state_r == replay_ctrl_pkg::ST_GAP |-> stopLevelSel && !memRdEn)
    else $error("gap not at stop level");
  a_len_clamp: assert property (@(posedge core_clk) disable iff (!nrst)
    regWrEn && regAddr == replay_ctrl_pkg::LEN_IDX
    |=> len_r <= maxLen($past(enabledChannels)))
    else $error("replay length above memory");
endmodule

/* File: replay_ctrl_pkg.sv */
// Purpose: Shared constants for the replay card command, status and sequencer
// Assumes: Register indices are the printed register numbers
// Notes: Card start/stop bits are local assignments in the command word
package replay_ctrl_pkg;

  // ==========================================================================
  // Register indices
  localparam logic [15:0] CMD_IDX = 16'h0064;
  localparam logic [15:0] STAT_IDX = 16'h006e;
  localparam logic [15:0] MODE_IDX = 16'h251c;
  localparam logic [15:0] LEN_IDX = 16'h2710;
  localparam logic [15:0] LOOPS_IDX = 16'h2724;

  // ==========================================================================
  // Command word bits
  localparam int CARD_START_BIT = 2;
  localparam int CARD_STOP_BIT = 6;
  localparam int XFER_START_BIT = 16;
  localparam int XFER_WAIT_BIT = 17;
  localparam int XFER_HALT_BIT = 18;

  // ==========================================================================
  // Status word bits
  localparam int BLK_RDY_BIT = 8;
  localparam int DONE_BIT = 9;
  localparam int OVR_BIT = 10;
  localparam int ERR_BIT = 11;
  localparam int WAIT_BUSY_BIT = 12;
  localparam int WAIT_TMO_BIT = 13;
  localparam int XFER_RUN_BIT = 14;
  localparam int REPLAY_RUN_BIT = 15;

  // ==========================================================================
  // Modes, reset values, beat size and clock period
  localparam logic [31:0] MODE_SINGLE = 32'h0000_0100;
  localparam logic [31:0] MODE_RETRIG = 32'h0000_8000;
  localparam logic [31:0] MODE_RST = 32'h0000_0100;
  localparam logic [31:0] LEN_RST = 32'h0000_0010;
  localparam logic [31:0] LOOPS_RST = 32'h0000_0001;
  localparam logic [31:0] BEAT_BYTES = 32'h0000_0004;
  localparam int CLK_PERIOD_NS = 40;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_PLAY = 2'b10,
    ST_GAP = 2'b11
  } replay_state_t;

endpackage

/* File: pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to core_clk
// Notes: A change is taken only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          pinOut[i] <= 1'b0;
        end else if (stage2_r[i] == stage3_r[i]) begin
          pinOut[i] <= stage3_r[i];
        end
      end
    end
  endgenerate

endmodule

/* File: host_model.sv */
// Purpose: Host driver model on the card's indexed register access
// Assumes: Strobes are launched by non-blocking assignment at core_clk rise
// Notes: Released write data is inverted so a stale word is never reused
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  output logic [15:0] regAddr,
  output logic regWrEn,
  output logic [31:0] regWrData,
  output logic regRdEn,
  input wire logic [31:0] regRdData,
  input wire logic regRdValid
);
  initial begin
    regAddr = 16'h0000;
    regWrEn = 1'b0;
    regWrData = 32'h0;
    regRdEn = 1'b0;
  end

  // ==========================================================================
  // Register cycles
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic v);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
    v = regRdValid;
  endtask

  // ==========================================================================
  // Driver habits
  task automatic set_len(input logic [31:0] n);
    wr(replay_ctrl_pkg::LEN_IDX, n);
  endtask

  // Halt first so a late beat cannot land in a freed buffer
  task automatic drop_buffer();
    wr(replay_ctrl_pkg::CMD_IDX, 32'h1 << replay_ctrl_pkg::XFER_HALT_BIT);
  endtask
endmodule

/* File: tb_top.sv */
// Purpose: Self-checking bench for transfer control and replay sequencer
// Assumes: host_model drives registers; this bench drives datapath strobes
// Notes: ADDR_W is cut to 8 so the length clamp is reachable
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] regAddr;
  logic regWrEn;
  logic regRdEn;
  logic regRdValid;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic acqDirection = 1'b0;
  logic [31:0] notifyChunkBytes = 32'h0;
  logic [31:0] xferTotalBytes = 32'h10;
  logic xferBeat = 1'b0;
  logic [31:0] waitTimeoutCycles = 32'h0;
  logic [2:0] enabledChannels = 3'h1;
  logic trigPin = 1'b0;
  logic fifoFault = 1'b0;
  logic internalFault = 1'b0;
  logic dmaRun;
  logic memRdEn;
  logic stopLevelSel;
  logic [7:0] memAddr;
  logic [31:0] seed = 32'h54dc;
  logic [31:0] s;
  logic [31:0] d;
  logic v;
  int n_errors = 0;
  int compares = 0;
  int samples = 0;
  int expAddr = 0;
  int cyc = 0;
  int nb;

  always #20 core_clk = ~core_clk;

  host_model host (.core_clk(core_clk), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid));

  replay_dma_ctrl #(.ADDR_W(8)) uut (.core_clk(core_clk), .nrst(nrst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .acqDirection(acqDirection), .notifyChunkBytes(notifyChunkBytes),
    .xferTotalBytes(xferTotalBytes), .xferBeat(xferBeat),
    .waitTimeoutCycles(waitTimeoutCycles),
    .enabledChannels(enabledChannels), .trigPin(trigPin),
    .fifoFault(fifoFault), .internalFault(internalFault), .dmaRun(dmaRun),
    .memAddr(memAddr), .memRdEn(memRdEn), .stopLevelSel(stopLevelSel));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] bitw(input int b);
    return 32'h1 << b;
  endfunction

  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic stat();
    host.rd(replay_ctrl_pkg::STAT_IDX, s, v);
    chk("regRdValid", {31'h0, v}, 32'h1);
  endtask

  task automatic flag(input string n, input int b, input logic e);
    chk(n, {31'h0, s[b]}, {31'h0, e});
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Gaps between beats are random, zero to two extra cycles before each beat, so beat timing varies
  task automatic beats(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (rnd() % 3) @(posedge core_clk);
      @(posedge core_clk);
      xferBeat <= 1'b1;
      @(posedge core_clk);
      xferBeat <= 1'b0;
    end
    #1;
  endtask

  task automatic xfer(input logic [31:0] nc, input logic [31:0] tot);
    @(posedge core_clk);
    notifyChunkBytes <= nc;
    xferTotalBytes <= tot;
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::XFER_START_BIT));
    #1;
    chk("dmaRun", {31'h0, dmaRun}, 32'h1);
  endtask

  task automatic trig();
    @(posedge core_clk);
    trigPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    trigPin <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic play(input logic [31:0] m, input logic [31:0] n,
                      input int t, input int e);
    host.wr(replay_ctrl_pkg::MODE_IDX, m);
    host.wr(replay_ctrl_pkg::LOOPS_IDX, n);
    host.set_len(32'h10);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::CARD_START_BIT));
    samples = 0;
    expAddr = 0;
    for (int i = 0; i < t; i++) begin
      trig();
      repeat (60) @(posedge core_clk);
      chk("stopLevelSel", {31'h0, stopLevelSel}, 32'h1);
    end
    chk("samples", samples, e);
    $display("test replay mode %h loops %0d done", m, n);
  endtask

  // ==========================================================================
  // Sample monitor and hang guard, off the launching edge
  always @(negedge core_clk) begin
    cyc++;
    if (memRdEn === 1'b1) begin
      chk("memAddr", {24'h0, memAddr}, expAddr);
      chk("stopLevelSel", {31'h0, stopLevelSel}, 32'h0);
      samples++;
      expAddr = (expAddr + 1) % 16;
    end
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    chk("dmaRun", {31'h0, dmaRun}, 32'h0);
    chk("stopLevelSel", {31'h0, stopLevelSel}, 32'h1);
    host.rd(replay_ctrl_pkg::MODE_IDX, d, v);
    chk("mode", d, replay_ctrl_pkg::MODE_RST);
    host.rd(replay_ctrl_pkg::LOOPS_IDX, d, v);
    chk("loops", d, replay_ctrl_pkg::LOOPS_RST);
    host.wr(replay_ctrl_pkg::MODE_IDX, replay_ctrl_pkg::MODE_RETRIG);
    host.wr(replay_ctrl_pkg::MODE_IDX, 32'h0800);
    host.rd(replay_ctrl_pkg::MODE_IDX, d, v);
    chk("mode", d, replay_ctrl_pkg::MODE_RETRIG);
    host.rd(replay_ctrl_pkg::CMD_IDX, d, v);
    chk("cmd", d, 32'h0);
    for (int c = 1; c <= 4; c *= 2) begin
      @(posedge core_clk);
      enabledChannels <= c[2:0];
      host.set_len(32'h3e8);
      host.rd(replay_ctrl_pkg::LEN_IDX, d, v);
      chk("len", d, 256 / c);
    end
    $display("test registers done");
    play(replay_ctrl_pkg::MODE_SINGLE, 32'h1, 2, 16);
    play(replay_ctrl_pkg::MODE_SINGLE, 32'h3, 1, 48);
    play(replay_ctrl_pkg::MODE_RETRIG, 32'h2, 3, 32);
    play(replay_ctrl_pkg::MODE_RETRIG, 32'h1, 2, 16);
    nb = 2 + rnd() % 5;
    xfer(32'h0, nb * 4);
    beats(nb);
    chk("dmaRun", {31'h0, dmaRun}, 32'h0);
    stat();
    flag("done", replay_ctrl_pkg::DONE_BIT, 1'b1);
    stat();
    flag("done", replay_ctrl_pkg::DONE_BIT, 1'b1);
    xfer(32'h8, 32'h20);
    beats(2);
    stat();
    flag("blockReady", replay_ctrl_pkg::BLK_RDY_BIT, 1'b1);
    beats(6);
    stat();
    flag("done", replay_ctrl_pkg::DONE_BIT, 1'b0);
    flag("blockReady", replay_ctrl_pkg::BLK_RDY_BIT, 1'b1);
    $display("test transfer end done");
    xfer(32'h0, 32'h20);
    beats(1);
    host.drop_buffer();
    #1;
    chk("dmaRun", {31'h0, dmaRun}, 32'h0);
    stat();
    flag("done", replay_ctrl_pkg::DONE_BIT, 1'b0);
    xfer(32'h0, 32'h20);
    @(posedge core_clk);
    fifoFault <= 1'b1;
    @(posedge core_clk);
    fifoFault <= 1'b0;
    internalFault <= 1'b1;
    @(posedge core_clk);
    internalFault <= 1'b0;
    stat();
    flag("overrun", replay_ctrl_pkg::OVR_BIT, 1'b1);
    flag("error", replay_ctrl_pkg::ERR_BIT, 1'b1);
    xfer(32'h0, 32'h20);
    stat();
    flag("overrun", replay_ctrl_pkg::OVR_BIT, 1'b0);
    flag("error", replay_ctrl_pkg::ERR_BIT, 1'b0);
    host.drop_buffer();
    $display("test halt and faults done");
    @(posedge core_clk);
    waitTimeoutCycles <= 32'h6;
    xfer(32'h0, 32'h10);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::XFER_WAIT_BIT));
    stat();
    flag("waitBusy", replay_ctrl_pkg::WAIT_BUSY_BIT, 1'b1);
    repeat (10) @(posedge core_clk);
    stat();
    flag("waitBusy", replay_ctrl_pkg::WAIT_BUSY_BIT, 1'b0);
    flag("waitTimeout", replay_ctrl_pkg::WAIT_TMO_BIT, 1'b1);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::XFER_WAIT_BIT));
    beats(4);
    stat();
    flag("waitBusy", replay_ctrl_pkg::WAIT_BUSY_BIT, 1'b0);
    $display("test wait done");
    @(posedge core_clk);
    acqDirection <= 1'b1;
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::CARD_START_BIT)
            | bitw(replay_ctrl_pkg::XFER_START_BIT));
    repeat (8) @(posedge core_clk);
    #1;
    chk("dmaRun", {31'h0, dmaRun}, 32'h0);
    stat();
    flag("pending", replay_ctrl_pkg::XFER_RUN_BIT, 1'b1);
    trig();
    #1;
    chk("dmaRun", {31'h0, dmaRun}, 32'h1);
    beats(4);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::CARD_STOP_BIT));
    acqDirection <= 1'b0;
    $display("test delayed start done");
    host.wr(replay_ctrl_pkg::MODE_IDX, replay_ctrl_pkg::MODE_SINGLE);
    host.wr(replay_ctrl_pkg::LOOPS_IDX, 32'h0);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::CARD_START_BIT));
    samples = 0;
    expAddr = 0;
    trig();
    repeat (60) @(posedge core_clk);
    #1;
    chk("memRdEn", {31'h0, memRdEn}, 32'h1);
    chk("endless", {31'h0, samples >= 60}, 32'h1);
    host.wr(replay_ctrl_pkg::CMD_IDX, bitw(replay_ctrl_pkg::CARD_STOP_BIT));
    repeat (4) @(posedge core_clk);
    #1;
    chk("memRdEn", {31'h0, memRdEn}, 32'h0);
    $display("test endless replay done");
    tally_and_finish();
  end
endmodule
